//--- inc/aicc_pkg.sv
`default_nettype none

package aicc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Widths and counts.
   localparam int DW    = 8;
   localparam int AW    = 8;
   localparam int NPORT = 2;
   localparam int NGRP  = 2;
   localparam int NPIN  = NPORT * 8;
   localparam int RES_W = 12;
   localparam int CH_W  = 6;
   localparam int OUT_W = 16;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets.
   localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
   localparam logic [AW-1:0] OFS_PCH    = 8'h01;
   localparam logic [AW-1:0] OFS_NCH    = 8'h02;
   localparam logic [AW-1:0] OFS_ACQ    = 8'h03;
   localparam logic [AW-1:0] OFS_CLKDIV = 8'h04;
   localparam logic [AW-1:0] OFS_STAT   = 8'h05;
   localparam logic [AW-1:0] OFS_RES_L  = 8'h06;
   localparam logic [AW-1:0] OFS_RES_H  = 8'h07;
   localparam logic [AW-1:0] OFS_PREV_L = 8'h08;
   localparam logic [AW-1:0] OFS_PREV_H = 8'h09;
   // Group enables start here, one byte per group and port: g*NPORT+p.
   localparam logic [AW-1:0] OFS_GRP    = 8'h10;

   ////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int CTRL_GO   = 0;
   localparam int CTRL_DIFF = 1;
   localparam int CTRL_CS   = 2;
   localparam int CTRL_REF  = 3;
   localparam int CTRL_DBL  = 4;
   localparam int CTRL_EN   = 7;
   localparam int STAT_DONE = 0;
   localparam int STAT_THR  = 1;
   localparam int STAT_BUSY = 2;
   localparam int STAT_NEG  = 3;

   ////////////////////////////////////////////////////////////////////////
   // Channel codes and converter constants.
   localparam logic [CH_W-1:0]  CH_GRP_BASE = 6'h20;
   localparam logic [RES_W-1:0] SAR_MID     = 12'h800;
   localparam logic [3:0]       SAR_TOP_BIT = 4'hB;
   localparam logic [CH_W-1:0]  PCH_RST     = 6'h00;
   localparam logic [7:0]       ACQ_RST     = 8'h00;
   localparam logic [5:0]       DIV_RST     = 6'h00;

   typedef enum logic [1:0] {
      PH_IDLE,
      PH_ACQ,
      PH_CONV,
      PH_STORE
   } aicc_phase_t;

   typedef struct packed {
      logic            diff;
      logic            cs;
      logic            ref_ext;
      logic            dbl;
      logic [CH_W-1:0] positive_channel_field;
      logic [CH_W-1:0] nch;
   } aicc_cfg_t;

   typedef struct packed {
      aicc_phase_t                     phase;
      logic                            en;
      aicc_cfg_t                       cfg;
      aicc_cfg_t                       act;
      logic [7:0]                      acq;
      logic [5:0]                      div;
      logic [NGRP*NPORT-1:0][7:0]      grp;
      logic [NGRP*NPORT-1:0][7:0]      grp_act;
      logic [6:0]                      div_cnt;
      logic [7:0]                      acq_cnt;
      logic [3:0]                      bit_idx;
      logic [RES_W-1:0]                code;
      logic                            second;
      logic [OUT_W-1:0]                res;
      logic [OUT_W-1:0]                prev;
      logic                            done_flag;
      logic                            thr_flag;
      logic [DW-1:0]                   rd_data;
      logic                            sample;
      logic [NPIN-1:0]                 pos_sw;
      logic                            wake;
      logic                            busy;
   } aicc_state_t;

endpackage : aicc_pkg

`default_nettype wire

//--- design/aicc_ctrl.sv
// Our own choices: the register addresses and strobed register access.

`default_nettype none

module aicc_ctrl (
   input  wire logic                     CLOCK_I,
   input  wire logic                     RST_I,
   input  wire logic [aicc_pkg::AW-1:0]  ADDR_I,
   input  wire logic [aicc_pkg::DW-1:0]  WR_DATA_I,
   input  wire logic                     WR_I,
   input  wire logic                     RD_I,
   input  wire logic                     COMP_I,
   input  wire logic                     OSC_TICK_I,
   input  wire logic                     THR_EVT_I,
   input  wire logic                     SLEEP_I,
   output logic [aicc_pkg::DW-1:0]       RD_DATA_O,
   output logic                          SAMPLE_O,
   output logic [aicc_pkg::RES_W-1:0]    SAR_CODE_O,
   output logic [aicc_pkg::NPIN-1:0]     POS_SW_O,
   output logic [aicc_pkg::CH_W-1:0]     POS_CH_O,
   output logic [aicc_pkg::CH_W-1:0]     NEG_CH_O,
   output logic                          NEG_EN_O,
   output logic                          REF_EXT_O,
   output logic                          BUSY_O,
   output logic                          DONE_IRQ_O,
   output logic                          THR_IRQ_O,
   output logic                          WAKE_O
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations.
   aicc_pkg::aicc_state_t              s_reg;
   aicc_pkg::aicc_state_t              s_next;
   logic [aicc_pkg::NPIN-1:0]          pin_sel;
   logic [aicc_pkg::NGRP-1:0]          grp_pick;
   logic [aicc_pkg::CH_W-1:0]          route_pch;
   logic [aicc_pkg::NGRP*aicc_pkg::NPORT-1:0][7:0] route_grp;

   ////////////////////////////////////////////////////////////////////////
   // Input routing.

   // The switches follow the programmed selection while idle and the frozen
   // copy during a sequence. Using the live copy while idle means the first
   // sampling cycle after a start already closes the new channel, never the
   // one left over from the previous conversion.
   assign route_pch = (s_reg.phase == aicc_pkg::PH_IDLE) ?
                      s_reg.cfg.positive_channel_field : s_reg.act.positive_channel_field;
   assign route_grp = (s_reg.phase == aicc_pkg::PH_IDLE) ?
                      s_reg.grp : s_reg.grp_act;

   // A group channel code picks that group's wired-OR input.
   genvar g;
   generate
      for (g = 0; g < aicc_pkg::NGRP; g++) begin : gen_grp
         assign grp_pick[g] = (route_pch ==
            aicc_pkg::CH_GRP_BASE + aicc_pkg::CH_W'(g));
      end
   endgenerate

   // Each pin closes when selected directly or through an enabled group.
   // The analog select bit of the pin plays no part, on purpose.
   genvar i;
   generate
      for (i = 0; i < aicc_pkg::NPIN; i++) begin : gen_pin
         logic [aicc_pkg::NGRP-1:0] in_grp;
         for (g = 0; g < aicc_pkg::NGRP; g++) begin : gen_mem
            // Only the picked group's register of this pin's port may enlist it.
            assign in_grp[g] = grp_pick[g] &
               route_grp[g*aicc_pkg::NPORT + i/8][i%8];
         end
         assign pin_sel[i] = (route_pch == aicc_pkg::CH_W'(i))
                           | (|in_grp);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // Bus, divider, sequencer and flags all resolve here in one pass.
   always_comb begin
      logic                        tick;
      logic                        start;
      logic                        abort;
      logic                        done_set;
      logic [aicc_pkg::RES_W-1:0]  offs;
      logic [aicc_pkg::OUT_W-1:0]  val;
      tick     = 1'b0;
      start    = 1'b0;
      abort    = 1'b0;
      done_set = 1'b0;
      offs     = s_reg.code ^ aicc_pkg::SAR_MID;
      val      = '0;
      s_next   = s_reg;
      s_next.rd_data = '0;
      s_next.wake    = 1'b0;

      // Conversion clock. The divided system clock stops in sleep, so
      // only the dedicated oscillator can finish a conversion there.
      if (s_reg.phase == aicc_pkg::PH_IDLE) begin
         s_next.div_cnt = '0;
      end else if (s_reg.act.cs) begin
         tick = OSC_TICK_I;
      end else if (SLEEP_I) begin
         s_next.div_cnt = s_reg.div_cnt;
      end else if (s_reg.div_cnt == {s_reg.div, 1'b1}) begin
         s_next.div_cnt = '0;
         tick           = 1'b1;
      end else begin
         s_next.div_cnt = s_reg.div_cnt + 7'h01;
      end

      // Register writes. Routing copies live in cfg until a start.
      if (WR_I) begin
         unique case (ADDR_I)
            aicc_pkg::OFS_CTRL: begin
               s_next.en          = WR_DATA_I[aicc_pkg::CTRL_EN];
               s_next.cfg.diff    = WR_DATA_I[aicc_pkg::CTRL_DIFF];
               s_next.cfg.cs      = WR_DATA_I[aicc_pkg::CTRL_CS];
               s_next.cfg.ref_ext = WR_DATA_I[aicc_pkg::CTRL_REF];
               s_next.cfg.dbl     = WR_DATA_I[aicc_pkg::CTRL_DBL];
               if (WR_DATA_I[aicc_pkg::CTRL_GO]) begin
                  start = WR_DATA_I[aicc_pkg::CTRL_EN] &&
                          (s_reg.phase == aicc_pkg::PH_IDLE);
               end else begin
                  abort = 1'b1;
               end
            end
            aicc_pkg::OFS_PCH: begin
               s_next.cfg.positive_channel_field = WR_DATA_I[aicc_pkg::CH_W-1:0];
            end
            aicc_pkg::OFS_NCH: begin
               s_next.cfg.nch = WR_DATA_I[aicc_pkg::CH_W-1:0];
            end
            aicc_pkg::OFS_ACQ: begin
               s_next.acq = WR_DATA_I;
            end
            aicc_pkg::OFS_CLKDIV: begin
               s_next.div = WR_DATA_I[5:0];
            end
            aicc_pkg::OFS_STAT: begin
               // Write one to clear; a same-cycle event wins below.
               if (WR_DATA_I[aicc_pkg::STAT_DONE]) begin
                  s_next.done_flag = 1'b0;
               end
               if (WR_DATA_I[aicc_pkg::STAT_THR]) begin
                  s_next.thr_flag = 1'b0;
               end
            end
            default: begin
               if (ADDR_I[7:2] == aicc_pkg::OFS_GRP[7:2]) begin
                  s_next.grp[ADDR_I[1:0]] = WR_DATA_I;
               end
            end
         endcase
      end

      // Register reads; the data stand only in the following cycle.
      if (RD_I) begin
         unique case (ADDR_I)
            aicc_pkg::OFS_CTRL: begin
               s_next.rd_data[aicc_pkg::CTRL_EN]   = s_reg.en;
               s_next.rd_data[aicc_pkg::CTRL_DIFF] = s_reg.cfg.diff;
               s_next.rd_data[aicc_pkg::CTRL_CS]   = s_reg.cfg.cs;
               s_next.rd_data[aicc_pkg::CTRL_REF]  = s_reg.cfg.ref_ext;
               s_next.rd_data[aicc_pkg::CTRL_DBL]  = s_reg.cfg.dbl;
               s_next.rd_data[aicc_pkg::CTRL_GO]   =
                  (s_reg.phase != aicc_pkg::PH_IDLE);
            end
            aicc_pkg::OFS_PCH: begin
               s_next.rd_data = {2'h0, s_reg.cfg.positive_channel_field};
            end
            aicc_pkg::OFS_NCH: begin
               s_next.rd_data = {2'h0, s_reg.cfg.nch};
            end
            aicc_pkg::OFS_ACQ: begin
               s_next.rd_data = s_reg.acq;
            end
            aicc_pkg::OFS_CLKDIV: begin
               s_next.rd_data = {2'h0, s_reg.div};
            end
            aicc_pkg::OFS_STAT: begin
               s_next.rd_data[aicc_pkg::STAT_DONE] = s_reg.done_flag;
               s_next.rd_data[aicc_pkg::STAT_THR]  = s_reg.thr_flag;
               s_next.rd_data[aicc_pkg::STAT_BUSY] =
                  (s_reg.phase != aicc_pkg::PH_IDLE);
               s_next.rd_data[aicc_pkg::STAT_NEG]  = s_reg.res[15];
            end
            aicc_pkg::OFS_RES_L: begin
               s_next.rd_data = s_reg.res[7:0];
            end
            aicc_pkg::OFS_RES_H: begin
               s_next.rd_data = s_reg.res[15:8];
            end
            aicc_pkg::OFS_PREV_L: begin
               s_next.rd_data = s_reg.prev[7:0];
            end
            aicc_pkg::OFS_PREV_H: begin
               s_next.rd_data = s_reg.prev[15:8];
            end
            default: begin
               if (ADDR_I[7:2] == aicc_pkg::OFS_GRP[7:2]) begin
                  s_next.rd_data = s_reg.grp[ADDR_I[1:0]];
               end
            end
         endcase
      end

      // Conversion sequencer.
      unique case (s_reg.phase)
         aicc_pkg::PH_IDLE: begin
            if (start) begin
               // Routing is frozen here and held until the next idle.
               s_next.act     = s_next.cfg;
               s_next.grp_act = s_next.grp;
               s_next.phase   = aicc_pkg::PH_ACQ;
               s_next.acq_cnt = '0;
               s_next.second  = 1'b0;
            end
         end
         aicc_pkg::PH_ACQ: begin
            if (tick) begin
               if (s_reg.acq_cnt == s_reg.acq) begin
                  s_next.phase   = aicc_pkg::PH_CONV;
                  s_next.bit_idx = aicc_pkg::SAR_TOP_BIT;
                  s_next.code    = aicc_pkg::SAR_MID;
               end else begin
                  s_next.acq_cnt = s_reg.acq_cnt + 8'h01;
               end
            end
         end
         aicc_pkg::PH_CONV: begin
            // One decision per converter clock, most significant first.
            if (tick) begin
               s_next.code[s_reg.bit_idx] = COMP_I;
               if (s_reg.bit_idx == 4'h0) begin
                  s_next.phase = aicc_pkg::PH_STORE;
               end else begin
                  s_next.code[s_reg.bit_idx - 4'h1] = 1'b1;
                  s_next.bit_idx = s_reg.bit_idx - 4'h1;
               end
            end
         end
         aicc_pkg::PH_STORE: begin
            // Differential codes are offset binary around mid-scale.
            if (s_reg.act.diff) begin
               val = {{4{offs[11]}}, offs};
            end else begin
               val = {4'h0, s_reg.code};
            end
            s_next.prev = s_reg.res;
            s_next.res  = val;
            if (s_reg.act.dbl && !s_reg.second) begin
               // Second sample reuses the frozen routing.
               s_next.second  = 1'b1;
               s_next.phase   = aicc_pkg::PH_ACQ;
               s_next.acq_cnt = '0;
            end else begin
               s_next.second = 1'b0;
               s_next.phase  = aicc_pkg::PH_IDLE;
               done_set      = 1'b1;
            end
         end
      endcase

      // Abort drops any partial result; the hold capacitor stays as is.
      // An abort in the store cycle keeps both results and the flag too, but the
      // first half of a double sample, once stored, stays in the result.
      if (abort || !s_next.en) begin
         s_next.phase  = aicc_pkg::PH_IDLE;
         s_next.second = 1'b0;
         s_next.res    = s_reg.res;
         s_next.prev   = s_reg.prev;
         done_set      = 1'b0;
      end

      // Events are applied last so that they beat a clear.
      if (done_set) begin
         s_next.done_flag = 1'b1;
      end
      if (THR_EVT_I) begin
         s_next.thr_flag = 1'b1;
      end
      s_next.wake = SLEEP_I & (done_set | THR_EVT_I);

      s_next.sample = (s_next.phase == aicc_pkg::PH_ACQ);
      s_next.pos_sw = s_next.sample ? pin_sel : '0;
      // Busy gets its own flop so that the pin carries no decode glitches.
      s_next.busy   = (s_next.phase != aicc_pkg::PH_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.

   // Every field, outputs included, comes out of reset as zero.
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, each a field of the state register.
   assign RD_DATA_O  = s_reg.rd_data;
   assign SAMPLE_O   = s_reg.sample;
   assign SAR_CODE_O = s_reg.code;
   assign POS_SW_O   = s_reg.pos_sw;
   assign POS_CH_O   = s_reg.act.positive_channel_field;
   assign NEG_CH_O   = s_reg.act.nch;
   assign NEG_EN_O   = s_reg.act.diff;
   assign REF_EXT_O  = s_reg.act.ref_ext;
   assign BUSY_O     = s_reg.busy;
   assign DONE_IRQ_O = s_reg.done_flag;
   assign THR_IRQ_O  = s_reg.thr_flag;
   assign WAKE_O     = s_reg.wake;

endmodule : aicc_ctrl

`default_nettype wire

//--- bench/aicc_ctrl_props.sv
`default_nettype none

module aicc_ctrl_props (
   input wire logic                      CLOCK_I,
   input wire logic                      RST_I,
   input wire logic [aicc_pkg::AW-1:0]   ADDR_I,
   input wire logic [aicc_pkg::DW-1:0]   WR_DATA_I,
   input wire logic                      WR_I,
   input wire logic                      RD_I,
   input wire logic                      THR_EVT_I,
   input wire logic                      SLEEP_I,
   input wire logic [aicc_pkg::DW-1:0]   RD_DATA_O,
   input wire logic                      SAMPLE_O,
   input wire logic [aicc_pkg::NPIN-1:0] POS_SW_O,
   input wire logic [aicc_pkg::CH_W-1:0] POS_CH_O,
   input wire logic                      NEG_EN_O,
   input wire logic                      BUSY_O,
   input wire logic                      DONE_IRQ_O,
   input wire logic                      THR_IRQ_O,
   input wire logic                      WAKE_O
);
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RST_I);

   ////////////////////////////////////////////////////////////////////////
   // Status clear strobes; nothing else may lower a flag.
   logic clr_done;
   logic clr_thr;
   logic ctrl_wr;
   assign clr_done = WR_I && ADDR_I == aicc_pkg::OFS_STAT && WR_DATA_I[0];
   assign clr_thr  = WR_I && ADDR_I == aicc_pkg::OFS_STAT && WR_DATA_I[1];
   assign ctrl_wr  = WR_I && ADDR_I == aicc_pkg::OFS_CTRL;

   // A conversion ends when busy drops without a control write (an abort).
   sequence conv_end_s;
      BUSY_O && !ctrl_wr ##1 !BUSY_O;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   // Read data stands only in the cycle after a read strobe.
   rd_idle_a: assert property (!$past(RD_I) |-> RD_DATA_O == '0)
      else $error("read data not zero outside a read answer");
   sw_sample_a: assert property (POS_SW_O != '0 |-> SAMPLE_O)
      else $error("input switch closed outside sampling");
   sample_busy_a: assert property (SAMPLE_O |-> BUSY_O)
      else $error("sampling while idle");
   route_hold_a: assert property (
      BUSY_O && $past(BUSY_O) && $past(BUSY_O, 2)
      |-> $stable(POS_CH_O) && $stable(NEG_EN_O))
      else $error("input routing changed mid conversion");
   done_set_a: assert property (conv_end_s |-> DONE_IRQ_O)
      else $error("done flag missing at end of conversion");
   done_clr_a: assert property (
      $fell(DONE_IRQ_O) |-> $past(clr_done))
      else $error("done flag cleared without a status write");
   thr_set_a: assert property ($past(THR_EVT_I) |-> THR_IRQ_O)
      else $error("threshold flag not raised");
   thr_clr_a: assert property ($fell(THR_IRQ_O) |-> $past(clr_thr))
      else $error("threshold flag cleared without a status write");
   wake_sleep_a: assert property (WAKE_O |-> $past(SLEEP_I))
      else $error("wake pulse while awake");
endmodule : aicc_ctrl_props

bind aicc_ctrl aicc_ctrl_props aicc_ctrl_props_i (
   .CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
   .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I),
   .THR_EVT_I(THR_EVT_I), .SLEEP_I(SLEEP_I), .RD_DATA_O(RD_DATA_O),
   .SAMPLE_O(SAMPLE_O), .POS_SW_O(POS_SW_O), .POS_CH_O(POS_CH_O),
   .NEG_EN_O(NEG_EN_O), .BUSY_O(BUSY_O), .DONE_IRQ_O(DONE_IRQ_O),
   .THR_IRQ_O(THR_IRQ_O), .WAKE_O(WAKE_O)
);

`default_nettype wire

//--- bench/aicc_analog_model.sv
`default_nettype none

module aicc_analog_model (
   input  wire logic [11:0] sar_code_i,
   input  wire logic        clk_i,
   input  wire logic [15:0] pos_sw_i,
   input  wire logic [5:0]  neg_ch_i,
   input  wire logic        neg_en_i,
   output logic             comp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] pin_lvl [16]; // Pin levels in codes, set by the bench.
   int          held = 0;
   int          pos;

   // Hold capacitor tracks the closed switches; grouped pins share one node,
   // so the highest level wins, a fair stand-in for a wire-OR.
   always @(posedge clk_i) begin
      if (pos_sw_i != 16'h0000) begin
         pos = 0;
         for (int i = 0; i < 16; i++) begin
            if (pos_sw_i[i] && pin_lvl[i] > pos) pos = pin_lvl[i];
         end
         held = pos;
         if (neg_en_i && neg_ch_i < 6'h10) begin
            held = pos - pin_lvl[neg_ch_i[3:0]] + 'h800;
         end
         held = held < 0 ? 0 : (held > 'hFFF ? 'hFFF : held);
      end
   end

   // Comparator: input at or above the trial code.
   assign comp_o = held >= sar_code_i;
endmodule : aicc_analog_model

`default_nettype wire

//--- bench/aicc_ctrl_bench.sv
`default_nettype none

module aicc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                      CLOCK_I = 1'b0;
   logic                      RST_I = 1'b1;
   logic [7:0]                ADDR_I = 8'h00;
   logic [7:0]                WR_DATA_I = 8'h00;
   logic                      WR_I = 1'b0;
   logic                      RD_I = 1'b0;
   logic                      OSC_TICK_I = 1'b0;
   logic                      THR_EVT_I = 1'b0;
   logic                      SLEEP_I = 1'b0;
   logic                      COMP_I;
   logic [7:0]                RD_DATA_O;
   logic [11:0]               SAR_CODE_O;
   logic [15:0]               POS_SW_O;
   logic [5:0]                POS_CH_O;
   logic [5:0]                NEG_CH_O;
   logic                      SAMPLE_O;
   logic                      NEG_EN_O;
   logic                      REF_EXT_O;
   logic                      BUSY_O;
   logic                      DONE_IRQ_O;
   logic                      THR_IRQ_O;
   logic                      WAKE_O;
   logic [1:0]                tick_cnt = 2'h0;
   int                        failures = 0;
   int                        cmp_count = 0;

   aicc_ctrl aicc_ctrl_i (
      .CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
      .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I), .COMP_I(COMP_I),
      .OSC_TICK_I(OSC_TICK_I), .THR_EVT_I(THR_EVT_I), .SLEEP_I(SLEEP_I),
      .RD_DATA_O(RD_DATA_O), .SAMPLE_O(SAMPLE_O), .SAR_CODE_O(SAR_CODE_O),
      .POS_SW_O(POS_SW_O), .POS_CH_O(POS_CH_O), .NEG_CH_O(NEG_CH_O),
      .NEG_EN_O(NEG_EN_O), .REF_EXT_O(REF_EXT_O), .BUSY_O(BUSY_O),
      .DONE_IRQ_O(DONE_IRQ_O), .THR_IRQ_O(THR_IRQ_O), .WAKE_O(WAKE_O));

   aicc_analog_model aicc_analog_model_i (
      .sar_code_i(SAR_CODE_O), .clk_i(CLOCK_I), .pos_sw_i(POS_SW_O),
      .neg_ch_i(NEG_CH_O), .neg_en_i(NEG_EN_O), .comp_o(COMP_I));

   ////////////////////////////////////////////////////////////////////////
   // System clock, 50 ns period.
   initial begin
      forever #25 CLOCK_I = ~CLOCK_I;
   end

   // Converter oscillator tick every fourth cycle; it runs in sleep too.
   always @(posedge CLOCK_I) begin
      tick_cnt <= tick_cnt + 2'h1;
      OSC_TICK_I <= (tick_cnt == 2'h3);
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [15:0] seen,
                      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Strobes are held across exactly one sampling edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLOCK_I);
      WR_I <= 1'b1;
      ADDR_I <= a;
      WR_DATA_I <= d;
      @(posedge CLOCK_I);
      WR_I <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge CLOCK_I);
      RD_I <= 1'b1;
      ADDR_I <= a;
      @(posedge CLOCK_I);
      RD_I <= 1'b0;
      @(posedge CLOCK_I);
      d = RD_DATA_O;
   endtask : rd

   // Reads one byte, or a low/high pair, and compares.
   task automatic rchk(input string what, input logic [7:0] a,
                       input bit wide, input logic [15:0] exp);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(a, lo);
      hi = 8'h00;
      if (wide) rd(a + 8'h01, hi);
      chk(what, {hi, lo}, exp);
   endtask : rchk

   // Bounded wait for sampling or for the done flag.
   task automatic wait_flag(input bit on_done);
      int n;
      n = 0;
      while ((on_done ? DONE_IRQ_O : SAMPLE_O) !== 1'b1) begin
         if (n == 400) begin
            failures++;
            $display("ERROR wait expected 1 seen 0");
            final_report();
         end
         n++;
         @(posedge CLOCK_I);
      end
   endtask : wait_flag

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      wr(8'h0F, 8'hFF);
      rchk("ctrl", aicc_pkg::OFS_CTRL, 1'b0, 16'h0000);
      rchk("stat", aicc_pkg::OFS_STAT, 1'b0, 16'h0000);
      rchk("unmapped", 8'h0F, 1'b0, 16'h0000);
   endtask : t_reset

   task automatic t_single;
      aicc_analog_model_i.pin_lvl[3] = 12'h5A3;
      wr(aicc_pkg::OFS_ACQ, 8'h03);
      wr(aicc_pkg::OFS_NCH, 8'h05);
      wr(aicc_pkg::OFS_PCH, 8'h03);
      wr(aicc_pkg::OFS_CTRL, 8'h81);
      wait_flag(1'b0);
      @(posedge CLOCK_I);
      chk("pos switches", POS_SW_O, 16'h0008);
      chk("neg used", {15'h0000, NEG_EN_O}, 16'h0000);
      wait_flag(1'b1);
      chk("sar code", {4'h0, SAR_CODE_O}, 16'h05A3);
      rchk("result", aicc_pkg::OFS_RES_L, 1'b1, 16'h05A3);
      rchk("stat done", aicc_pkg::OFS_STAT, 1'b0, 16'h0001);
      wr(aicc_pkg::OFS_STAT, 8'h01);
      rchk("stat clear", aicc_pkg::OFS_STAT, 1'b0, 16'h0000);
   endtask : t_single

   // Differential on the oscillator clock while asleep, external reference.
   task automatic t_diff;
      aicc_analog_model_i.pin_lvl[2] = 12'h100;
      aicc_analog_model_i.pin_lvl[5] = 12'h300;
      SLEEP_I <= 1'b1;
      wr(aicc_pkg::OFS_PCH, 8'h02);
      wr(aicc_pkg::OFS_CTRL, 8'h8F);
      wait_flag(1'b0);
      @(posedge CLOCK_I);
      chk("pos switches", POS_SW_O, 16'h0004);
      chk("neg used", {15'h0000, NEG_EN_O}, 16'h0001);
      chk("neg channel", {10'h000, NEG_CH_O}, 16'h0005);
      chk("ref ext", {15'h0000, REF_EXT_O}, 16'h0001);
      wait_flag(1'b1);
      chk("wake done", {15'h0000, WAKE_O}, 16'h0001);
      SLEEP_I <= 1'b0;
      rchk("result", aicc_pkg::OFS_RES_L, 1'b1, 16'hFE00);
      rchk("previous", aicc_pkg::OFS_PREV_L, 1'b1, 16'h05A3);
      rchk("stat sign", aicc_pkg::OFS_STAT, 1'b0, 16'h0009);
      wr(aicc_pkg::OFS_STAT, 8'h01);
   endtask : t_diff

   // Sample a grounded pin, abort after acquisition: no result, no flag.
   task automatic t_discharge;
      wr(aicc_pkg::OFS_PCH, 8'h00);
      wr(aicc_pkg::OFS_CTRL, 8'h81);
      wait_flag(1'b0);
      repeat (12) @(posedge CLOCK_I);
      wr(aicc_pkg::OFS_CTRL, 8'h80);
      @(posedge CLOCK_I);
      chk("abort busy", {15'h0000, BUSY_O}, 16'h0000);
      rchk("abort stat", aicc_pkg::OFS_STAT, 1'b0, 16'h0008);
      rchk("abort result", aicc_pkg::OFS_RES_L, 1'b1, 16'hFE00);
   endtask : t_discharge

   // Group 1 spread over both ports, double sample.
   task automatic t_group;
      aicc_analog_model_i.pin_lvl[8] = 12'h3C0;
      aicc_analog_model_i.pin_lvl[15] = 12'h3C0;
      wr(aicc_pkg::OFS_GRP, 8'hFF);
      wr(aicc_pkg::OFS_GRP + 8'h02, 8'h04);
      wr(aicc_pkg::OFS_GRP + 8'h03, 8'h81);
      rchk("group enable", aicc_pkg::OFS_GRP + 8'h03, 1'b0, 16'h0081);
      wr(aicc_pkg::OFS_PCH, {2'h0, aicc_pkg::CH_GRP_BASE + 6'h01});
      wr(aicc_pkg::OFS_CTRL, 8'h91);
      wait_flag(1'b0);
      @(posedge CLOCK_I);
      chk("group switches", POS_SW_O, 16'h8104);
      wait_flag(1'b1);
      rchk("result", aicc_pkg::OFS_RES_L, 1'b1, 16'h03C0);
      rchk("previous", aicc_pkg::OFS_PREV_L, 1'b1, 16'h03C0);
      wr(aicc_pkg::OFS_STAT, 8'h01);
   endtask : t_group

   task automatic t_thr;
      @(posedge CLOCK_I);
      THR_EVT_I <= 1'b1;
      SLEEP_I <= 1'b1;
      @(posedge CLOCK_I);
      THR_EVT_I <= 1'b0;
      @(posedge CLOCK_I);
      chk("thr flag", {15'h0000, THR_IRQ_O}, 16'h0001);
      chk("wake", {15'h0000, WAKE_O}, 16'h0001);
      SLEEP_I <= 1'b0;
      wr(aicc_pkg::OFS_STAT, 8'h02);
      @(posedge CLOCK_I);
      chk("thr clear", {15'h0000, THR_IRQ_O}, 16'h0000);
   endtask : t_thr

   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for six cycles, then each scenario in turn.
   initial begin
      foreach (aicc_analog_model_i.pin_lvl[i]) begin
         aicc_analog_model_i.pin_lvl[i] = 12'h000;
      end
      repeat (6) @(posedge CLOCK_I);
      RST_I <= 1'b0;
      t_reset();
      t_single();
      t_diff();
      t_discharge();
      t_group();
      t_thr();
      final_report();
   end
endmodule : aicc_ctrl_bench

`default_nettype wire
